// file: include/atx_pkg.sv
// Shared constants and types for the ARINC 429 transmit and label filter core
package atx_pkg;
  localparam int unsigned ATX_WORD_W = 32;
  localparam int unsigned ATX_TX_DEPTH = 32;
  localparam int unsigned ATX_LVL_W = 6;
  localparam logic [ATX_LVL_W-1:0] ATX_HALF_LEVEL = 6'h10;
  localparam logic [ATX_LVL_W-1:0] ATX_FULL_LEVEL = 6'h20;
  localparam int unsigned ATX_LABELS = 256;

  // Instruction codes
  localparam logic [7:0] OP_TBL_WRITE = 8'h02;
  localparam logic [7:0] OP_TBL_ALL_ON = 8'h03;
  localparam logic [7:0] OP_TBL_ALL_OFF = 8'h06;
  localparam logic [7:0] OP_DIV_WRITE = 8'h07;
  localparam logic [7:0] OP_TBL_READ = 8'h0D;
  localparam logic [7:0] OP_TX_WRITE = 8'h0E;
  localparam logic [7:0] OP_TX_CLEAR = 8'h11;
  localparam logic [7:0] OP_TX_SEND = 8'h12;

  // Bit timing in reference clocks
  localparam logic [8:0] HS_HALF_BIT_REF = 9'h005;
  localparam logic [8:0] LS_HALF_BIT_REF = 9'h028;
  localparam logic [8:0] HS_GAP_REF = 9'h028;
  localparam logic [8:0] LS_GAP_REF = 9'h140;
  localparam logic [4:0] LAST_BIT_IDX = 5'h1F;
  localparam logic [1:0] LAST_WORD_BYTE = 2'h3;
  localparam logic [2:0] LAST_SPI_BIT = 3'h7;
  localparam logic [4:0] TBL_FIRST_BYTE = 5'h1F;
  localparam logic [7:0] TBL_FIRST_ENTRY = 8'hFF;
  localparam logic [7:0] DIV_RESET = 8'h01;

  // Synchronised pin positions
  localparam int unsigned PIN_N = 5;
  localparam int unsigned PIN_ACLK = 0;
  localparam int unsigned PIN_SCK = 1;
  localparam int unsigned PIN_CSN = 2;
  localparam int unsigned PIN_SI = 3;
  localparam int unsigned PIN_MCLR = 4;
  localparam logic [PIN_N-1:0] PIN_RST = 5'h04;

  typedef enum logic [1:0] {TX_IDLE, TX_MARK, TX_NULL, TX_GAP} atx_tx_state_t;

  typedef struct packed {
    logic empty;
    logic half;
    logic full;
  } atx_flags_t;
endpackage

// file: hw/atx_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and a synchronous clear
module atx_fifo
  import atx_pkg::*;
#(
  parameter int unsigned WIDTH = ATX_WORD_W,
  parameter int unsigned DEPTH = ATX_TX_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clr,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [CW-1:0] cnt_ff;

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_ff != CNT_FULL);
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign level = cnt_ff;

  // Depth is a power of two, so pointers wrap naturally
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else if (clr) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
      if (pop) rd_ptr_ff <= AW'(rd_ptr_ff + 1'b1);
      cnt_ff <= CW'(cnt_ff + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, pop});
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) mem_ff[wr_ptr_ff] <= in_data;
  end
endmodule

// file: hw/atx_core.sv
// ARINC 429 transmitter, label filter and SPI slave command port
module atx_core
  import atx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic aclk,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  input wire logic master_clear_pin,
  input wire logic label_filter_enable,
  input wire logic tx_parity_enable,
  input wire logic tx_parity_even_select,
  input wire logic tx_auto_send,
  input wire logic tx_rate_slow_select,
  input wire logic ref_clock_divide_select,
  input wire logic loopback_off,
  input wire logic line_output_null_force,
  input wire logic rx_word_strobe,
  input wire logic [7:0] rx_word_label,
  input wire logic rx_fifo_nonempty,
  output logic rx_word_keep,
  output logic rx_fifo_state_pin,
  output logic tx_fifo_state_pin,
  output logic tx_fifo_empty_flag,
  output logic tx_fifo_half_flag,
  output logic tx_fifo_full_flag,
  output logic line_output_a,
  output logic line_output_b,
  output logic rx_loop_a,
  output logic rx_loop_b
);
  // Parity bit sits in bit 32 (index 31) of the word
  function automatic logic [ATX_WORD_W-1:0] add_parity(input logic [ATX_WORD_W-1:0] w,
                                                       input logic en, input logic even);
    logic [ATX_WORD_W-1:0] r;
    r = w;
    if (en) r[ATX_WORD_W-1] = (^w[ATX_WORD_W-2:0]) ^ ~even;
    return r;
  endfunction
  function automatic logic op_is(input logic [7:0] op, input logic [7:0] code);
    return op == code;
  endfunction
  // Pin synchronisers: a change counts once stages two and three agree
  logic [PIN_N-1:0] s1_ff, s2_ff, s3_ff, pin_ff, pin_rise, pin_fall;
  wire [PIN_N-1:0] pins = {master_clear_pin, si, cs_n, sck, aclk};
  generate
    for (genvar g = 0; g < PIN_N; g++) begin : g_sync
      wire settle = (s2_ff[g] == s3_ff[g]);
      assign pin_rise[g] = settle && s3_ff[g] && !pin_ff[g];
      assign pin_fall[g] = settle && !s3_ff[g] && pin_ff[g];
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          s1_ff[g] <= PIN_RST[g];
          s2_ff[g] <= PIN_RST[g];
          s3_ff[g] <= PIN_RST[g];
          pin_ff[g] <= PIN_RST[g];
        end else begin
          s1_ff[g] <= pins[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          if (settle) pin_ff[g] <= s3_ff[g];
        end
      end
    end
  endgenerate

  wire mclr = pin_ff[PIN_MCLR];
  wire cs_active = !pin_ff[PIN_CSN];
  wire cs_rise = pin_rise[PIN_CSN];
  wire sck_rise = pin_rise[PIN_SCK] && cs_active;
  wire sck_fall = pin_fall[PIN_SCK] && cs_active;
  wire si_val = pin_ff[PIN_SI];

  // SPI command port state
  logic [2:0] bit_cnt_ff;
  logic [7:0] sh_ff, op_ff, rd_ptr_ff, div_ratio_ff;
  logic hdr_done_ff, loaded_ff, so_ff, so_oe_ff, push_ff, fifo_in_ready;
  logic [1:0] word_byte_ff;
  logic [23:0] word_hi_ff;
  logic [4:0] tbl_byte_ff;
  logic [ATX_WORD_W-1:0] push_word_ff;
  logic [ATX_LABELS-1:0] label_tbl_ff, nxt_label_tbl;

  // Read data phase: serial input is not sampled at all
  wire rd_phase = hdr_done_ff && op_is(op_ff, OP_TBL_READ);
  wire byte_done = sck_rise && !rd_phase && (bit_cnt_ff == LAST_SPI_BIT);
  wire [7:0] full_byte = {sh_ff[6:0], si_val};
  wire op_now = byte_done && !hdr_done_ff;
  wire data_now = byte_done && hdr_done_ff;
  wire cmd_tbl_on = op_now && op_is(full_byte, OP_TBL_ALL_ON);
  wire cmd_tbl_off = op_now && op_is(full_byte, OP_TBL_ALL_OFF);
  wire cmd_tx_clear = op_now && op_is(full_byte, OP_TX_CLEAR);
  wire cmd_tx_send = op_now && op_is(full_byte, OP_TX_SEND);
  wire wr_tbl = data_now && op_is(op_ff, OP_TBL_WRITE);
  wire wr_div = data_now && op_is(op_ff, OP_DIV_WRITE);
  wire wr_tx = data_now && op_is(op_ff, OP_TX_WRITE);
  wire wr_tx_last = wr_tx && (word_byte_ff == LAST_WORD_BYTE);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bit_cnt_ff <= '0;
      sh_ff <= '0;
      hdr_done_ff <= 1'b0;
      op_ff <= '0;
    end else if (!cs_active) begin
      bit_cnt_ff <= '0;
      hdr_done_ff <= 1'b0;
    end else if (sck_rise && !rd_phase) begin
      bit_cnt_ff <= 3'(bit_cnt_ff + 1'b1);
      sh_ff <= full_byte;
      if (op_now) begin
        op_ff <= full_byte;
        hdr_done_ff <= 1'b1;
      end
    end
  end

  // Table and transmit word byte positions; each access starts afresh
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      word_byte_ff <= '0;
      word_hi_ff <= '0;
      tbl_byte_ff <= TBL_FIRST_BYTE;
      loaded_ff <= 1'b0;
    end else if (!cs_active) begin
      word_byte_ff <= '0;
      tbl_byte_ff <= TBL_FIRST_BYTE;
      loaded_ff <= 1'b0;
    end else begin
      if (wr_tbl) tbl_byte_ff <= 5'(tbl_byte_ff - 1'b1);
      if (wr_tx) begin
        word_byte_ff <= 2'(word_byte_ff + 1'b1);
        word_hi_ff <= {word_hi_ff[15:0], full_byte};
      end
      if (wr_tx_last) loaded_ff <= 1'b1;
    end
  end

  // A word completed while the FIFO is full is simply not taken
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      push_ff <= 1'b0;
      push_word_ff <= '0;
    end else begin
      push_ff <= wr_tx_last && fifo_in_ready && !mclr;
      if (wr_tx_last) push_word_ff <= {word_hi_ff, full_byte};
    end
  end

  always_comb begin
    nxt_label_tbl = label_tbl_ff;
    if (cmd_tbl_on) nxt_label_tbl = '1;
    else if (cmd_tbl_off) nxt_label_tbl = '0;
    else if (wr_tbl) nxt_label_tbl[{tbl_byte_ff, 3'h0} +: 8] = full_byte;
  end

  // The table survives master clear; only the transmit FIFO is emptied
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) label_tbl_ff <= '0;
    else label_tbl_ff <= nxt_label_tbl;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) div_ratio_ff <= DIV_RESET;
    else if (wr_div) div_ratio_ff <= full_byte;
  end

  // Read data changes on the falling clock so the host samples it on the rise
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
      rd_ptr_ff <= TBL_FIRST_ENTRY;
    end else if (!cs_active) begin
      so_oe_ff <= 1'b0;
      rd_ptr_ff <= TBL_FIRST_ENTRY;
    end else if (sck_fall && rd_phase) begin
      so_ff <= label_tbl_ff[rd_ptr_ff];
      so_oe_ff <= 1'b1;
      rd_ptr_ff <= 8'(rd_ptr_ff - 1'b1);
    end
  end

  // Receive label filter
  logic rx_keep_ff, rx_state_ff;
  wire label_hit = label_tbl_ff[rx_word_label];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_keep_ff <= 1'b0;
      rx_state_ff <= 1'b0;
    end else begin
      rx_keep_ff <= rx_word_strobe && !mclr && (!label_filter_enable || label_hit);
      rx_state_ff <= rx_fifo_nonempty && !mclr;
    end
  end

  // Transmit FIFO
  logic fifo_out_valid, tx_pop;
  logic [ATX_WORD_W-1:0] fifo_out_data;
  logic [ATX_LVL_W-1:0] fifo_level;
  wire fifo_clr = mclr || cmd_tx_clear;

  atx_fifo #(
    .WIDTH(ATX_WORD_W),
    .DEPTH(ATX_TX_DEPTH)
  ) u_tx_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .clr(fifo_clr),
    .in_valid(push_ff),
    .in_ready(fifo_in_ready),
    .in_data(push_word_ff),
    .out_valid(fifo_out_valid),
    .out_ready(tx_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // Reference tick: direct 1 MHz edges, or edges divided by the loaded ratio
  logic [7:0] div_cnt_ff;
  wire aclk_edge = pin_rise[PIN_ACLK];
  wire div_wrap = (8'(div_cnt_ff + 1'b1) >= div_ratio_ff);
  wire ref_tick = aclk_edge && (!ref_clock_divide_select || div_wrap);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) div_cnt_ff <= '0;
    else if (aclk_edge) div_cnt_ff <= div_wrap ? '0 : 8'(div_cnt_ff + 1'b1);
  end

  // Transmit engine
  atx_tx_state_t state_ff, nxt_state;
  logic [8:0] phase_cnt_ff;
  logic [4:0] bit_idx_ff;
  logic [ATX_WORD_W-1:0] tx_sh_ff;
  logic arm_ff;

  wire [8:0] half_len = tx_rate_slow_select ? LS_HALF_BIT_REF : HS_HALF_BIT_REF;
  wire [8:0] gap_len = tx_rate_slow_select ? LS_GAP_REF : HS_GAP_REF;
  wire [8:0] phase_len = (state_ff == TX_GAP) ? gap_len : half_len;
  wire phase_end = ref_tick && (phase_cnt_ff == 9'(phase_len - 1'b1));
  wire tx_idle = (state_ff == TX_IDLE);
  wire arm_set = cmd_tx_send || (cs_rise && tx_auto_send && loaded_ff);
  wire arm_drop = tx_idle && !fifo_out_valid;
  assign tx_pop = tx_idle && arm_ff && fifo_out_valid && !fifo_clr;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      TX_IDLE: begin
        if (tx_pop) nxt_state = TX_MARK;
      end
      TX_MARK: begin
        if (phase_end) nxt_state = TX_NULL;
      end
      TX_NULL: begin
        if (phase_end) nxt_state = (bit_idx_ff == LAST_BIT_IDX) ? TX_GAP : TX_MARK;
      end
      TX_GAP: begin
        if (phase_end) nxt_state = TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff <= TX_IDLE;
      phase_cnt_ff <= '0;
      bit_idx_ff <= '0;
      tx_sh_ff <= '0;
    end else if (mclr) begin
      state_ff <= TX_IDLE;
      phase_cnt_ff <= '0;
      bit_idx_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (tx_pop) begin
        tx_sh_ff <= add_parity(fifo_out_data, tx_parity_enable, tx_parity_even_select);
        phase_cnt_ff <= '0;
        bit_idx_ff <= '0;
      end else if (phase_end) begin
        phase_cnt_ff <= '0;
        if (state_ff == TX_NULL) begin
          tx_sh_ff <= {1'b0, tx_sh_ff[ATX_WORD_W-1:1]};
          bit_idx_ff <= 5'(bit_idx_ff + 1'b1);
        end
      end else if (ref_tick) begin
        phase_cnt_ff <= 9'(phase_cnt_ff + 1'b1);
      end
    end
  end

  // A send request racing the drain still wins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) arm_ff <= 1'b0;
    else if (mclr) arm_ff <= 1'b0;
    else arm_ff <= arm_set || (arm_ff && !arm_drop);
  end

  // Line levels: one is A high, zero is B high, null is both low
  wire drive = (state_ff == TX_MARK);
  wire nxt_a = drive && tx_sh_ff[0];
  wire nxt_b = drive && !tx_sh_ff[0];
  wire loop_en = !loopback_off && !line_output_null_force;

  logic line_a_ff, line_b_ff, loop_a_ff, loop_b_ff;
  atx_flags_t flags_ff, nxt_flags;
  assign nxt_flags = '{empty: !fifo_out_valid && tx_idle,
    half: fifo_level >= ATX_HALF_LEVEL,
    full: fifo_level == ATX_FULL_LEVEL};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line_a_ff <= 1'b0;
      line_b_ff <= 1'b0;
      loop_a_ff <= 1'b0;
      loop_b_ff <= 1'b0;
      flags_ff <= '{empty: 1'b1, half: 1'b0, full: 1'b0};
    end else begin
      line_a_ff <= nxt_a && !line_output_null_force && !mclr;
      line_b_ff <= nxt_b && !line_output_null_force && !mclr;
      loop_a_ff <= nxt_a && loop_en && !mclr;
      loop_b_ff <= nxt_b && loop_en && !mclr;
      flags_ff <= mclr ? atx_flags_t'{empty: 1'b1, half: 1'b0, full: 1'b0} : nxt_flags;
    end
  end

  assign so = so_ff;
  assign so_oe = so_oe_ff;
  assign rx_word_keep = rx_keep_ff;
  assign rx_fifo_state_pin = rx_state_ff;
  assign tx_fifo_state_pin = flags_ff.empty;
  assign tx_fifo_empty_flag = flags_ff.empty;
  assign tx_fifo_half_flag = flags_ff.half;
  assign tx_fifo_full_flag = flags_ff.full;
  assign line_output_a = line_a_ff;
  assign line_output_b = line_b_ff;
  assign rx_loop_a = loop_a_ff;
  assign rx_loop_b = loop_b_ff;
endmodule

// file: verification/atx_core_sva.sv
// Concurrent checks on the transmit, label filter and serial pins of the core
module atx_core_sva
  import atx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic so_oe,
  input wire logic master_clear_pin,
  input wire logic label_filter_enable,
  input wire logic loopback_off,
  input wire logic line_output_null_force,
  input wire logic rx_word_strobe,
  input wire logic rx_word_keep,
  input wire logic tx_fifo_state_pin,
  input wire logic tx_fifo_empty_flag,
  input wire logic tx_fifo_half_flag,
  input wire logic tx_fifo_full_flag,
  input wire logic line_output_a,
  input wire logic line_output_b,
  input wire logic rx_loop_a,
  input wire logic rx_loop_b
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  keep_cause_a: assert property (rx_word_keep |-> $past(rx_word_strobe)) else $error("keep without strobe");
  filter_off_a: assert property (rx_word_strobe && !label_filter_enable |=> rx_word_keep)
    else $error("word dropped with filter off");
  full_half_a: assert property (tx_fifo_full_flag |-> tx_fifo_half_flag && !tx_fifo_empty_flag)
    else $error("full flag without half flag");
  // Two cycles allow the flag and line registers to settle in either order
  idle_null_a: assert property (tx_fifo_empty_flag [*2] |-> !line_output_a && !line_output_b)
    else $error("line active while idle");
  null_force_a: assert property (line_output_null_force [*3] |-> !line_output_a && !line_output_b)
    else $error("line active under null force");
  loop_off_a: assert property (loopback_off [*3] |-> !rx_loop_a && !rx_loop_b)
    else $error("loopback active while off");
  loop_copy_a: assert property ((!loopback_off && !line_output_null_force) [*3] |->
    (rx_loop_a == line_output_a || rx_loop_a == $past(line_output_a)) &&
    (rx_loop_b == line_output_b || rx_loop_b == $past(line_output_b))) else $error("loopback differs from line");
  so_idle_a: assert property (cs_n [*8] |-> !so_oe) else $error("serial out driven while deselected");
  mclr_flags_a: assert property (master_clear_pin [*7] |-> tx_fifo_empty_flag && !tx_fifo_half_flag &&
    !tx_fifo_full_flag && !line_output_a && !line_output_b) else $error("master clear left activity");
  state_pin_a: assert property (tx_fifo_state_pin == tx_fifo_empty_flag) else $error("tx state pin differs");
  cover property ($rose(tx_fifo_full_flag));
  cover property ($rose(so_oe));
  cover property ($rose(line_output_a));
  cover property (rx_word_keep);
endmodule
bind atx_core atx_core_sva u_atx_core_sva (.*);

// file: verification/atx_host_model.sv
// Host side serial mode 0 master that drives the core's command port
module atx_host_model
  import atx_pkg::*;
(
  input wire logic core_clk,
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
    si = 1'h0;
  end
  // Eight core clocks per half period keep each pin stable past the pin synchroniser
  task automatic half();
    repeat (8) @(negedge core_clk);
  endtask
  task automatic frame_open();
    half();
    cs_n = 1'h0;
    half();
  endtask
  // Select goes high after every instruction since they cannot be chained
  task automatic frame_close();
    half();
    si = 1'h0;
    cs_n = 1'h1;
    half();
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      half();
      sck = 1'h1;
      rx[i] = so_oe ? so : 1'hx;
      half();
      sck = 1'h0;
    end
  endtask
  // Deliberately short burst that leaves a partial byte
  task automatic stub(input int n);
    for (int i = 0; i < n; i++) begin
      half();
      sck = 1'h1;
      half();
      sck = 1'h0;
    end
  endtask
endmodule

// file: verification/atx_core_bench.sv
// Self-checking bench for the transmit, label filter and command port core
module atx_core_bench
  import atx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0, rst = 1'h1, aclk = 1'h0, mclr = 1'h0, stb = 1'h0, rxne = 1'h0;
  logic filt_en = 1'h0, par_en = 1'h0, par_even = 1'h0, auto_s = 1'h0, slow = 1'h0;
  logic div_sel = 1'h0, lb_off = 1'h0, nullf = 1'h0, sck, cs_n, si, so, so_oe, keep, rxst, txst;
  logic emp, hf, full, la, lb, loop_a, loop_b;
  logic [7:0] lbl = 8'h00;
  logic [7:0] r;
  logic [255:0] tbl = '0;
  logic [31:0] txq[$];
  int seed = 32'hFD12, bad_count = 0, cmp_count = 0;
  atx_core u_atx_core (.core_clk, .rst, .aclk, .sck, .cs_n, .si, .so, .so_oe, .master_clear_pin(mclr),
    .label_filter_enable(filt_en), .tx_parity_enable(par_en), .tx_parity_even_select(par_even),
    .tx_auto_send(auto_s), .tx_rate_slow_select(slow), .ref_clock_divide_select(div_sel),
    .loopback_off(lb_off), .line_output_null_force(nullf), .rx_word_strobe(stb), .rx_word_label(lbl),
    .rx_fifo_nonempty(rxne), .rx_word_keep(keep), .rx_fifo_state_pin(rxst), .tx_fifo_state_pin(txst),
    .tx_fifo_empty_flag(emp), .tx_fifo_half_flag(hf), .tx_fifo_full_flag(full), .line_output_a(la),
    .line_output_b(lb), .rx_loop_a(loop_a), .rx_loop_b(loop_b));
  atx_host_model u_host (.core_clk, .sck, .cs_n, .si, .so, .so_oe);
  initial forever #4 core_clk = ~core_clk;
  // Direct reference of twelve core clocks keeps bit times exact and runs short
  initial forever begin
    repeat (6) @(negedge core_clk);
    aclk = ~aclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic cmd(input logic [7:0] op, input int nd, input logic [7:0] d);
    u_host.frame_open();
    u_host.xfer(op, r);
    if (nd > 0) u_host.xfer(d, r);
    u_host.frame_close();
  endtask
  task automatic chk_flags();
    cyc(4);
    check(emp, txq.size() == 0, "empty flag");
    check(hf, txq.size() >= 16, "half flag");
    check(full, txq.size() == 32, "full flag");
    check(txst, txq.size() == 0, "tx state pin");
  endtask
  task automatic strobe(input logic [7:0] l);
    logic seen;
    lbl = l;
    stb = 1'h1;
    cyc(1);
    stb = 1'h0;
    seen = keep;
    cyc(1);
    seen |= keep;
    check(seen, !filt_en || tbl[l], "label keep");
  endtask
  task automatic tbl_xfer(input logic [7:0] op);
    u_host.frame_open();
    u_host.xfer(op, r);
    for (int k = 0; k < 32; k++) begin
      if (op == OP_TBL_WRITE) tbl[255-8*k -: 8] = 8'($random(seed));
      u_host.xfer(op == OP_TBL_WRITE ? tbl[255-8*k -: 8] : 8'($random(seed)), r);
      if (op == OP_TBL_READ) check(r, tbl[255-8*k -: 8], "table byte");
    end
    if (op == OP_TBL_WRITE) u_host.stub(5);
    u_host.frame_close();
  endtask
  task automatic load(input int n);
    logic [31:0] w;
    u_host.frame_open();
    u_host.xfer(OP_TX_WRITE, r);
    for (int i = 0; i < n; i++) begin
      w = $random(seed);
      for (int k = 3; k >= 0; k--) u_host.xfer(w[8*k +: 8], r);
      if (txq.size() < 32) txq.push_back(w);
    end
    u_host.frame_close();
  endtask
  task automatic wait_act(input logic act, output int n);
    n = 0;
    while (((la || lb) != act) && n < 9000) begin
      cyc(1);
      n++;
    end
  endtask
  // The first mark may already be running when capture starts, so it is not timed
  task automatic cap_word();
    logic [31:0] w, e;
    int n, bad, lp;
    bad = 0;
    lp = 0;
    e = txq.pop_front();
    if (par_en) e[31] = par_even ? ^e[30:0] : ~^e[30:0];
    for (int i = 0; i < 32; i++) begin
      wait_act(1'h1, n);
      if (i > 0 && n != 60) bad++;
      if (la === lb) bad++;
      w[i] = la;
      if ({loop_a, loop_b} !== {la, lb}) lp++;
      wait_act(1'h0, n);
      if (i > 0 && n != 60) bad++;
    end
    check(w, e, "sent word");
    check(bad, 0, "bit timing");
    check(lp, 0, "loopback copy");
  endtask
  task automatic first_mark(input int exp_len);
    int n;
    load(1);
    check(la ^ lb, 1'h1, "first bit delay");
    wait_act(1'h1, n);
    wait_act(1'h0, n);
    wait_act(1'h1, n);
    check(n, exp_len, "first null length");
    nullf = 1'h1;
    cyc(8);
    check({la, lb}, 2'h0, "null force");
    nullf = 1'h0;
    mclr = 1'h1;
    cyc(10);
    txq.delete();
    check({la, lb, rxst}, 3'h0, "master clear");
    chk_flags();
    mclr = 1'h0;
    cyc(300);
    check({la, lb}, 2'h0, "no resume");
  endtask
  initial begin
    cyc(16);
    rst = 1'h0;
    cyc(6);
    chk_flags();
    tdone("reset");
    rxne = 1'h1;
    cyc(2);
    check(rxst, 1'h1, "rx state pin");
    cmd(OP_TBL_ALL_OFF, 0, 8'h00);
    tbl = '0;
    filt_en = 1'h1;
    repeat (4) strobe(8'($random(seed)));
    cmd(OP_TBL_ALL_ON, 0, 8'h00);
    tbl = '1;
    repeat (4) strobe(8'($random(seed)));
    tbl_xfer(OP_TBL_WRITE);
    tbl_xfer(OP_TBL_READ);
    repeat (24) strobe(8'($random(seed)));
    filt_en = 1'h0;
    repeat (4) strobe(8'($random(seed)));
    tdone("labels");
    load(15);
    chk_flags();
    load(18);
    chk_flags();
    cmd(OP_TX_CLEAR, 0, 8'h00);
    txq.delete();
    chk_flags();
    tdone("fifo");
    par_en = 1'h1;
    load(2);
    cyc(400);
    check({la, lb}, 2'h0, "held until send");
    cmd(OP_TX_SEND, 0, 8'h00);
    cap_word();
    cap_word();
    cyc(700);
    chk_flags();
    par_even = 1'h1;
    auto_s = 1'h1;
    load(1);
    cap_word();
    par_en = 1'h0;
    load(1);
    cap_word();
    cyc(700);
    chk_flags();
    tdone("transmit");
    slow = 1'h1;
    lb_off = 1'h1;
    first_mark(480);
    slow = 1'h0;
    lb_off = 1'h0;
    cmd(OP_DIV_WRITE, 1, 8'h02);
    div_sel = 1'h1;
    first_mark(120);
    tdone("rates");
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    bad_count++;
    give_verdict();
  end
endmodule
